// ### pkg/dsc_params.svh
// Constants of the front-panel switch decoder: offsets, switch positions,
// protected word spans, codes and timing.
// Assumes it is included by bare name by the synchroniser, the top level and the bench.
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the APB)
// ----------------------------------------------------------------------
`define DSC_OFF_SWCFG      12'h000
`define DSC_OFF_SETUP_MODE 12'h004
`define DSC_OFF_SETUP_BATT 12'h008
`define DSC_OFF_STATUS     12'h00C

// ----------------------------------------------------------------------
// Switch positions (switch n sits at bit n-1 of the pin vector)
// ----------------------------------------------------------------------
`define DSC_SW_PROTECT  0
`define DSC_SW_AUTOXFER 1
`define DSC_SW_ENGLISH  2
`define DSC_SW_EXPUSER  3
`define DSC_SW_SERSTD   4
`define DSC_SW_USER     5
`define DSC_SW_PERANY   6
`define DSC_SW_PROTOOL  7

// ----------------------------------------------------------------------
// Data memory word spans (6144..6568, 6600..6655, 6645, 6650)
// ----------------------------------------------------------------------
`define DSC_RODM_LO      16'h1800
`define DSC_RODM_HI      16'h19A8
`define DSC_SETUP_LO     16'h19C8
`define DSC_SETUP_HI     16'h19FF
`define DSC_RS232_CFG_LO 16'h19F5
`define DSC_PERI_CFG_LO  16'h19FA

// ----------------------------------------------------------------------
// Standard serial frame: host command protocol, 1 start, even, 7 data, 2 stop
// ----------------------------------------------------------------------
`define DSC_STD_DATA_BITS 4'h7
`define DSC_STD_STOP_BITS 2'h2
`define DSC_STD_BAUD      16'h2580

// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define DSC_MODE_PROGRAM 2'h0
`define DSC_MODE_MONITOR 2'h1
`define DSC_MODE_RUN     2'h2
`define DSC_START_SWITCH 8'h00
`define DSC_START_LAST   8'h01
`define DSC_START_FIELD  8'h02
`define DSC_DEV_NONE     2'h0
`define DSC_DEV_CONSOLE  2'h1
`define DSC_DEV_OTHER    2'h2
`define DSC_XSEL_PROG    2'h0
`define DSC_XSEL_RODM    2'h1
`define DSC_XSEL_SETUP   2'h2
`define DSC_XSEL_EXP     2'h3
`define DSC_BATT_SUPPRESS 4'h1
`define DSC_SETUP_RST    16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DSC_PCLK_MHZ   250
`define DSC_SETTLE_NS  1000
`define DSC_SETTLE_CYC ((`DSC_SETTLE_NS * `DSC_PCLK_MHZ + 999) / 1000)

`endif

// ### pkg/dsc_pkg.sv
// Types shared by the switch decoder modules.
// Assumes nothing beyond a SystemVerilog compiler.
package dsc_pkg;

  typedef enum logic [1:0] {
    dsc_st_settle,
    dsc_st_latch,
    dsc_st_xfer,
    dsc_st_ready
  } dsc_state_e;

  typedef struct packed {
    logic write_protect;
    logic auto_xfer;
    logic lang_english;
    logic exp_user;
    logic serial_std;
    logic periph_any;
    logic proto_tool;
    logic periph_std;
    logic rs232_std;
  } dsc_cfg_s;

  typedef struct packed {
    logic        valid;
    logic        space;
    logic [15:0] addr;
  } dsc_pdreq_s;

  typedef struct packed {
    logic ack;
    logic ok;
  } dsc_pdrsp_s;

  typedef struct packed {
    logic       req;
    logic [1:0] sel;
  } dsc_xfer_s;

  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
  } dsc_sync_s;

  typedef struct packed {
    dsc_state_e  st;
    logic [7:0]  settle;
    dsc_cfg_s    cfg;
    logic        user_mirror;
    logic [1:0]  op_mode;
    logic        mode_valid;
    logic [15:0] setup_mode;
    logic [15:0] setup_batt;
    dsc_pdrsp_s  pd_rsp;
    logic        pd_rej_flag;
    dsc_xfer_s   xfer;
    logic        exp_restore;
    logic        batt_err;
    logic        held_lost;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dsc_top_s;

endpackage

// ### logic/dsc_sync.sv
// Two-stage synchroniser for the switch and battery pins.
// Assumes asynchronous pin levels and the decoder's pclk domain.
`include "dsc_params.svh"

module dsc_sync (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [8:0] d,
  output logic      [8:0] q
);

  dsc_pkg::dsc_sync_s r;
  dsc_pkg::dsc_sync_s next_r;

  // First stage feeds only the second stage
  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;

endmodule

// ### logic/dsc_span.sv
// Inclusive word-address window compare.
// Assumes the address comes from logic on the same clock.
module dsc_span #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hFFFF
) (
  input  wire logic [15:0] addr,
  output logic             hit
);

  assign hit = (addr >= LO) && (addr <= HI);

endmodule

// ### logic/dsc_top.sv
// Front-panel switch decoder: samples seven switches after power-on, mirrors the user one,
// gates programming-device writes, runs the cassette auto-transfer,
// picks port settings and the startup mode, and flags battery trouble.
// Assumes an APB master on pclk, and that the write-request, device-kind
// and cassette signals come from logic on the same clock.
//
// How it works
// - Protect switch on rejects protected device writes
// - Auto-transfer switch copies cassette at start-up
// - Expansion switch off skips expansion info copy
// - Expansion switch selects user or default codes
// - Power-on with expansion off restores defaults
// - Serial switch on forces standard port frames
// - Peripheral switch off ignores standard peripheral
// - Serial switch off uses setup words
// - User switch mirrored continuously to auxiliary bit
// - Peripheral switch off accepts console only
// - Language switch on selects English messages
// - No battery loses held areas at power-off
// - Setup nibble suppresses battery error detection
// - Startup field zero takes mode from switch
`include "dsc_params.svh"

module dsc_top (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        sw_pin,
  input  wire logic              battery_ok_pin,
  input  wire logic [1:0]        dev_kind,
  input  wire logic [1:0]        console_mode,
  input  wire logic              cable_run,
  input  wire dsc_pkg::dsc_pdreq_s pd_req,
  output dsc_pkg::dsc_pdrsp_s    pd_rsp,
  output dsc_pkg::dsc_xfer_s     xfer,
  input  wire logic              xfer_done,
  output dsc_pkg::dsc_cfg_s      cfg,
  output logic                   user_switch_mirror_bit,
  output logic      [1:0]        op_mode,
  output logic                   mode_valid,
  output logic                   exp_restore,
  output logic                   batt_err,
  output logic                   held_lost
);

  // ----------------------------------------------------------------------
  // Pin synchronisation and write windows
  // ----------------------------------------------------------------------
  logic [8:0] pins;
  logic [7:0] sw;
  logic       batt_ok;
  logic       hit_rodm;
  logic       hit_setup;

  dsc_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({battery_ok_pin, sw_pin}),
    .q       (pins)
  );

  assign sw      = pins[7:0];
  assign batt_ok = pins[8];

  dsc_span #(.LO(`DSC_RODM_LO), .HI(`DSC_RODM_HI)) u_rodm (
    .addr (pd_req.addr),
    .hit  (hit_rodm)
  );

  dsc_span #(.LO(`DSC_SETUP_LO), .HI(`DSC_SETUP_HI)) u_setup (
    .addr (pd_req.addr),
    .hit  (hit_setup)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dsc_pkg::dsc_top_s q;
  dsc_pkg::dsc_top_s next_q;

  logic       protected_hit;
  logic       apb_setup;
  logic       apb_commit;
  logic [1:0] start_mode;
  logic       rej_event;
  logic       xfer_last;

  // Program space is protected whole; data memory only in its two windows
  assign protected_hit = !pd_req.space || hit_rodm || hit_setup;
  assign apb_setup     = psel && penable && !q.pready;
  assign apb_commit    = psel && penable && q.pready;
  assign rej_event     = pd_req.valid && !(q.st == dsc_pkg::dsc_st_ready
                         && !(q.cfg.write_protect && protected_hit));
  // The expansion block is last only when the expansion switch is on
  assign xfer_last     = (q.xfer.sel == `DSC_XSEL_EXP)
                         || (q.xfer.sel == `DSC_XSEL_SETUP && !q.cfg.exp_user);

  // Startup mode from the setup word and, for field zero, the switch
  always_comb begin
    start_mode = `DSC_MODE_PROGRAM;
    case (q.setup_mode[15:8])
      `DSC_START_SWITCH: begin
        case (dev_kind)
          `DSC_DEV_NONE: begin
            start_mode = q.cfg.periph_any ? `DSC_MODE_RUN : `DSC_MODE_PROGRAM;
          end
          `DSC_DEV_CONSOLE: begin
            start_mode = q.cfg.periph_any ? `DSC_MODE_PROGRAM : console_mode;
          end
          `DSC_DEV_OTHER: begin
            start_mode = (q.cfg.periph_any && cable_run) ? `DSC_MODE_RUN
                                                         : `DSC_MODE_PROGRAM;
          end
          default: start_mode = `DSC_MODE_PROGRAM;
        endcase
      end
      // Only the mode held since reset is known; no memory across power loss
      `DSC_START_LAST:  start_mode = q.op_mode;
      `DSC_START_FIELD: start_mode = q.setup_mode[1:0];
      default:          start_mode = `DSC_MODE_PROGRAM;
    endcase
  end

  always_comb begin
    next_q = q;
    next_q.pd_rsp      = '0;
    next_q.exp_restore = 1'b0;
    next_q.user_mirror = sw[`DSC_SW_USER];
    next_q.batt_err    = !batt_ok
                         && (q.setup_batt[15:12] != `DSC_BATT_SUPPRESS);

    // ----------------------------------------------------------------------
    // Power-on sequence
    // ----------------------------------------------------------------------
    case (q.st)
      dsc_pkg::dsc_st_settle: begin
        // Let the switch contacts and synchroniser settle before sampling
        if (q.settle == 8'(`DSC_SETTLE_CYC - 1)) begin
          next_q.st = dsc_pkg::dsc_st_latch;
        end else begin
          next_q.settle = q.settle + 8'h01;
        end
      end
      dsc_pkg::dsc_st_latch: begin
        // One sample per power cycle; later moves are not seen except on the user switch mirror
        next_q.cfg.write_protect = sw[`DSC_SW_PROTECT];
        next_q.cfg.auto_xfer     = sw[`DSC_SW_AUTOXFER];
        next_q.cfg.lang_english  = sw[`DSC_SW_ENGLISH];
        next_q.cfg.exp_user      = sw[`DSC_SW_EXPUSER];
        next_q.cfg.serial_std    = sw[`DSC_SW_SERSTD];
        next_q.cfg.periph_any    = sw[`DSC_SW_PERANY];
        next_q.cfg.proto_tool    = sw[`DSC_SW_PROTOOL];
        next_q.cfg.rs232_std     = sw[`DSC_SW_SERSTD];
        next_q.cfg.periph_std    = sw[`DSC_SW_SERSTD]
                                   && sw[`DSC_SW_PERANY];
        // Any changed code assignments are dropped for the defaults
        next_q.exp_restore       = !sw[`DSC_SW_EXPUSER];
        // Without a battery the held areas did not survive power-off
        next_q.held_lost         = !batt_ok;
        if (sw[`DSC_SW_AUTOXFER]) begin
          next_q.st       = dsc_pkg::dsc_st_xfer;
          next_q.xfer.req = 1'b1;
          next_q.xfer.sel = `DSC_XSEL_PROG;
        end else begin
          next_q.st = dsc_pkg::dsc_st_ready;
        end
      end
      dsc_pkg::dsc_st_xfer: begin
        if (xfer_done) begin
          if (xfer_last) begin
            next_q.xfer.req = 1'b0;
            next_q.st       = dsc_pkg::dsc_st_ready;
          end else begin
            next_q.xfer.sel = q.xfer.sel + 2'h1;
          end
        end
      end
      dsc_pkg::dsc_st_ready: begin
        // Mode is chosen once, after any cassette data is in place
        if (!q.mode_valid) begin
          next_q.op_mode    = start_mode;
          next_q.mode_valid = 1'b1;
        end
      end
      default: next_q.st = dsc_pkg::dsc_st_settle;
    endcase

    // ----------------------------------------------------------------------
    // Programming-device writes
    // ----------------------------------------------------------------------
    if (pd_req.valid) begin
      next_q.pd_rsp.ack = 1'b1;
      next_q.pd_rsp.ok  = !rej_event;
    end

    // ----------------------------------------------------------------------
    // APB slave: one wait state, answer registered
    // ----------------------------------------------------------------------
    next_q.pready  = apb_setup;
    next_q.pslverr = 1'b0;
    next_q.prdata  = '0;
    if (apb_setup) begin
      case (paddr)
        `DSC_OFF_SWCFG: begin
          next_q.prdata = {21'h00000, q.cfg.rs232_std, q.cfg.periph_std,
                           q.user_mirror, 1'b0, q.cfg.write_protect,
                           q.cfg.auto_xfer, q.cfg.lang_english, q.cfg.exp_user,
                           q.cfg.serial_std, q.cfg.periph_any, q.cfg.proto_tool};
        end
        `DSC_OFF_SETUP_MODE: next_q.prdata = {16'h0000, q.setup_mode};
        `DSC_OFF_SETUP_BATT: next_q.prdata = {16'h0000, q.setup_batt};
        `DSC_OFF_STATUS: begin
          next_q.prdata = {24'h000000, 1'b0, q.xfer.req, q.pd_rej_flag,
                           q.held_lost, q.batt_err, q.mode_valid, q.op_mode};
        end
        default: next_q.pslverr = 1'b1;
      endcase
    end
    if (apb_commit && pwrite) begin
      case (paddr)
        `DSC_OFF_SETUP_MODE: next_q.setup_mode = pwdata[15:0];
        `DSC_OFF_SETUP_BATT: next_q.setup_batt = pwdata[15:0];
        `DSC_OFF_STATUS: begin
          if (pwdata[5]) begin
            next_q.pd_rej_flag = 1'b0;
          end
        end
        default: next_q.pd_rej_flag = q.pd_rej_flag;
      endcase
    end
    // A rejection in the clearing cycle still leaves the flag set
    if (rej_event) begin
      next_q.pd_rej_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q            <= '0;
      q.st         <= dsc_pkg::dsc_st_settle;
      q.setup_mode <= `DSC_SETUP_RST;
      q.setup_batt <= `DSC_SETUP_RST;
      q.op_mode    <= `DSC_MODE_PROGRAM;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata                 = q.prdata;
  assign pready                 = q.pready;
  assign pslverr                = q.pslverr;
  assign pd_rsp                 = q.pd_rsp;
  assign xfer                   = q.xfer;
  assign cfg                    = q.cfg;
  assign user_switch_mirror_bit = q.user_mirror;
  assign op_mode                = q.op_mode;
  assign mode_valid             = q.mode_valid;
  assign exp_restore            = q.exp_restore;
  assign batt_err               = q.batt_err;
  assign held_lost              = q.held_lost;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_protect_reject: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pd_req.valid && q.cfg.write_protect && protected_hit)
      |=> (pd_rsp.ack && !pd_rsp.ok))
    else $error("protected write was accepted");

  chk_open_accept: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pd_req.valid && q.st == dsc_pkg::dsc_st_ready && !q.cfg.write_protect)
      |=> (pd_rsp.ack && pd_rsp.ok))
    else $error("unprotected write was rejected");

  chk_xfer_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    xfer.req |-> (q.cfg.auto_xfer && q.st == dsc_pkg::dsc_st_xfer))
    else $error("cassette copy without auto-transfer");

  chk_exp_skip: assert property (
    @(posedge pclk) disable iff (!presetn)
    (xfer.req && xfer.sel == `DSC_XSEL_EXP) |-> q.cfg.exp_user)
    else $error("expansion info copied with switch off");

  chk_exp_restore: assert property (
    @(posedge pclk) disable iff (!presetn)
    exp_restore |-> (!cfg.exp_user ##1 !exp_restore [*4]))
    else $error("default restore wrong or repeated");

  chk_periph_std: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.st == dsc_pkg::dsc_st_ready)
      |-> (cfg.periph_std == (cfg.serial_std && cfg.periph_any)
           && cfg.rs232_std == cfg.serial_std))
    else $error("port standard selection wrong");

  // Only compared once the pin history no longer reaches back into reset
  chk_user_mirror: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn, 3)
      |-> (user_switch_mirror_bit == $past(sw_pin[`DSC_SW_USER], 3)))
    else $error("user switch mirror lags or differs");

  chk_batt_suppress: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.setup_batt[15:12] == `DSC_BATT_SUPPRESS) |=> !batt_err)
    else $error("battery error raised while suppressed");

  chk_start_switch: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.st == dsc_pkg::dsc_st_ready && !q.mode_valid && dev_kind == `DSC_DEV_NONE
     && q.setup_mode[15:8] == `DSC_START_SWITCH)
      |=> (mode_valid && op_mode == ($past(q.cfg.periph_any) ? `DSC_MODE_RUN
                                                              : `DSC_MODE_PROGRAM)))
    else $error("startup mode does not follow switch");

  chk_cfg_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.st == dsc_pkg::dsc_st_ready) |=> $stable(cfg))
    else $error("latched configuration changed");

  chk_apb_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> (pready ##1 !pready))
    else $error("apb answer not one cycle after access");

endmodule

// ### tb/dsc_partner.sv
// Cassette model: answers each block copy with a one-cycle done pulse.
// Assumes the decoder's pclk domain and its xfer request level.
module dsc_partner (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire dsc_pkg::dsc_xfer_s xfer,
  input  wire logic [3:0]         lag,
  output logic                    xfer_done,
  output logic [7:0]              blk_log,
  output logic [2:0]              n_blk
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] cnt;

  // ----
  // Block copy, lag+1 cycles each, so prompt and slow cassettes both occur
  // ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      xfer_done <= 1'b0;
      blk_log <= 8'h00;
      n_blk <= 3'h0;
    end else begin
      xfer_done <= 1'b0;
      // No pulse in the done cycle: sel only moves at the following edge
      if (xfer.req && !xfer_done) begin
        if (cnt == lag) begin
          xfer_done <= 1'b1;
          cnt <= 4'h0;
          blk_log <= {blk_log[5:0], xfer.sel};
          n_blk <= n_blk + 3'h1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// ### tb/dip_switch_config_decoder_bench.sv
// Bench for the switch decoder: random power cycles, cassette copy,
// startup mode, write gating, battery flags and APB access.
// Assumes the decoder package, its defines and the cassette model.
`include "dsc_params.svh"

module dip_switch_config_decoder_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] sw_pin = 8'h00;
  logic battery_ok_pin = 1'b1;
  logic [1:0] dev_kind = 2'h0;
  logic [1:0] console_mode = 2'h0;
  logic cable_run = 1'b0;
  dsc_pkg::dsc_pdreq_s pd_req = '0;
  dsc_pkg::dsc_pdrsp_s pd_rsp;
  dsc_pkg::dsc_xfer_s xfer;
  logic xfer_done;
  dsc_pkg::dsc_cfg_s cfg;
  logic user_switch_mirror_bit;
  logic [1:0] op_mode;
  logic mode_valid;
  logic exp_restore;
  logic batt_err;
  logic held_lost;
  logic [3:0] lag = 4'h0;
  logic [7:0] blk_log;
  logic [2:0] n_blk;
  int n_fail = 0;
  int n_compared = 0;
  int n_restore = 0;
  int addr_tab [9] = '{0, 6143, 6144, 6568, 6569, 6599, 6600, 6655, 6656};

  dsc_top dsc_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sw_pin, .battery_ok_pin, .dev_kind, .console_mode, .cable_run,
    .pd_req, .pd_rsp, .xfer, .xfer_done, .cfg, .user_switch_mirror_bit, .op_mode,
    .mode_valid, .exp_restore, .batt_err, .held_lost
  );

  dsc_partner dsc_partner_i (
    .pclk, .presetn, .xfer, .lag, .xfer_done, .blk_log, .n_blk
  );

  always #2 pclk = ~pclk;

  always @(posedge pclk) begin
    if (exp_restore === 1'b1) n_restore++;
  end

  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait limit here: only the watchdog ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pd_write(input logic sp, input logic [15:0] a, input logic ok);
    @(posedge pclk);
    pd_req <= {1'b1, sp, a};
    @(posedge pclk);
    pd_req.valid <= 1'b0;
    @(posedge pclk);
    chk(32'({pd_rsp.ack, pd_rsp.ok}), 32'({1'b1, ok}));
  endtask

  function automatic logic prot(input logic sp, input int a);
    return !sp || (a >= 6144 && a <= 6568) || (a >= 6600 && a <= 6655);
  endfunction

  function automatic logic [1:0] exp_mode(input logic [15:0] sm, input logic pa);
    if (sm[15:8] == 8'h02) return sm[1:0];
    if (sm[15:8] == 8'h01) return 2'h0;
    case (dev_kind)
      2'h0: return pa ? 2'h2 : 2'h0;
      2'h1: return pa ? 2'h0 : console_mode;
      default: return (pa && cable_run) ? 2'h2 : 2'h0;
    endcase
  endfunction

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end

  // ----
  // Power cycles
  // ----
  initial begin
    logic [7:0] s;
    logic [8:0] ec;
    logic [15:0] sm;
    logic [1:0] bn;
    logic b;
    logic [31:0] r;
    logic [31:0] st;
    logic e;
    int k;
    void'($urandom(80));
    for (int it = 0; it < 8; it++) begin
      @(posedge pclk);
      s = 8'($urandom);
      b = 1'($urandom);
      ec = {s[0], s[1], s[2], s[3], s[4], s[6], s[7], s[4] & s[6], s[4]};
      presetn <= 1'b0;
      sw_pin <= s;
      battery_ok_pin <= b;
      dev_kind <= 2'($urandom_range(2));
      console_mode <= 2'($urandom_range(2));
      cable_run <= 1'($urandom);
      lag <= 4'($urandom);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      n_restore = 0;
      // Setup words go in before the latch so the startup decision sees them
      sm = {8'($urandom_range(2)), 8'($urandom_range(2))};
      bn = 2'($urandom_range(2));
      apb(1'b1, `DSC_OFF_SETUP_MODE, {16'h0, sm}, r, e);
      apb(1'b1, `DSC_OFF_SETUP_BATT, {18'h0, bn, 12'h000}, r, e);
      pd_write(1'b1, 16'h0000, 1'b0);
      k = 0;
      while (mode_valid !== 1'b1 && k < 1000) begin
        @(posedge pclk);
        k++;
      end
      chk(32'(mode_valid), 32'h1);
      chk(32'(cfg), 32'(ec));
      chk(32'(n_restore), 32'(!s[3]));
      chk(32'({n_blk, blk_log}), s[1] ? (s[3] ? 32'h41B : 32'h306) : 32'h0);
      chk(32'(op_mode), 32'(exp_mode(sm, s[6])));
      chk(32'({held_lost, batt_err}), 32'({!b, !b && bn != 2'h1}));
      // Operator turns the protocol-tool switch off before online writes
      sw_pin[7] <= 1'b0;
      for (int j = 0; j < 9; j++) begin
        pd_write(j != 0, 16'(addr_tab[j]), !(s[0] && prot(j != 0, addr_tab[j])));
      end
      apb(1'b0, `DSC_OFF_SWCFG, 32'h0, r, e);
      chk(r, {21'h0, s[4], s[4] & s[6], s[5], 1'b0, s[0], s[1], s[2], s[3], s[4], s[6], s[7]});
      apb(1'b0, `DSC_OFF_SETUP_MODE, 32'h0, r, e);
      chk(r, {16'h0, sm});
      apb(1'b0, `DSC_OFF_SETUP_BATT, 32'h0, r, e);
      chk(r, {18'h0, bn, 12'h000});
      // The early write before ready was refused, so the sticky flag is up
      st = {24'h0, 2'h0, 1'b1, !b, !b && bn != 2'h1, 1'b1, exp_mode(sm, s[6])};
      apb(1'b0, `DSC_OFF_STATUS, 32'h0, r, e);
      chk(r, st);
      apb(1'b1, `DSC_OFF_STATUS, 32'h20, r, e);
      apb(1'b0, `DSC_OFF_STATUS, 32'h0, r, e);
      chk(r, st & 32'hFFFFFFDF);
      apb(1'b0, 12'h010, 32'h0, r, e);
      chk(32'(e), 32'h1);
      // Every switch goes opposite to its power-on setting; only the user switch may follow before power-off
      sw_pin <= ~s;
      repeat (4) @(posedge pclk);
      chk(32'(user_switch_mirror_bit), 32'(!s[5]));
      chk(32'(cfg), 32'(ec));
    end
    wrap_up();
  end
endmodule
